// [rtl/tocm_pkg.sv]
// What this block does
// - straps sampled once at power-up, then frozen
// - full recalibration forced at power-up and on hold timeout
// - strap pair decodes mode and hold timeout
// - dc mode: output high while detection holds
// - dc timeout: recalibrate, output off until new
// - toggle mode: each new detection flips output
// - toggle timeout: recalibrate, output state kept
// - pulse mode: one fixed pulse per detection
// - pulse mode keeps piezo tone disabled
// - output tri-stated briefly before every burst
// - inactive output driven low outside health gap
// - tone of fixed length after new detection
// - tone driven differentially on both sense pins
// - detection valid after four consecutive bursts
// - hold timer reaching limit forces recalibration
`default_nettype none
package tocm_pkg;
   // output modes chosen by the straps
   typedef enum logic [1:0] {
      MODE_DC,
      MODE_TOGGLE,
      MODE_PULSE
   } tocm_mode_t;

   // clock and timing figures
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned HB_TIME_US     = 350;
   localparam int unsigned PULSE_TIME_MS  = 95;
   localparam int unsigned TONE_TIME_MS   = 95;
   localparam int unsigned TONE_FREQ_HZ   = 4000;
   localparam int unsigned HOLD_SHORT_S   = 10;
   localparam int unsigned HOLD_LONG_S    = 60;
   localparam int unsigned HB_CYC         = HB_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PULSE_CYC      = PULSE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned TONE_CYC       = TONE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned TONE_HALF_CYC  = CLK_HZ / (2 * TONE_FREQ_HZ);
   localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_S * CLK_HZ;
   localparam int unsigned HOLD_LONG_CYC  = HOLD_LONG_S * CLK_HZ;
   localparam int unsigned INTEG_LIMIT    = 4;
   localparam int unsigned TIMER_W        = 30;

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_IRQST = 8'h08;
   localparam logic [7:0] OFS_IRQMK = 8'h0C;

   // control fields
   localparam int unsigned CTRL_TONE_EN = 0;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0001;

   // status fields
   localparam int unsigned STAT_MODE_LSB = 0;
   localparam int unsigned STAT_LONG     = 2;
   localparam int unsigned STAT_DET      = 3;
   localparam int unsigned STAT_OUT      = 4;
   localparam int unsigned STAT_TONE     = 5;
   localparam int unsigned STAT_CFG_OK   = 6;
   localparam int unsigned STAT_INT_LSB  = 8;

   // interrupt event bits
   localparam int unsigned IRQ_DET   = 0;
   localparam int unsigned IRQ_TMO   = 1;
   localparam int unsigned IRQ_W     = 2;
   localparam logic [1:0]  IRQ_MK_RST = 2'h0;
endpackage
`default_nettype wire

// [rtl/tocm_tone_if.sv]
`timescale 1ns/1ps
`default_nettype none
// link between output control and the piezo tone generator
interface tocm_tone_if;
   logic start;   // one-cycle start request
   logic active;  // tone running
   logic drv_a;   // level for sense pin a
   logic drv_b;   // level for sense pin b

   modport ctrl (output start, input active, drv_a, drv_b);
   modport gen  (input start, output active, drv_a, drv_b);
endinterface
`default_nettype wire

// [rtl/tocm_tone.sv]
`timescale 1ns/1ps
`default_nettype none
module tocm_tone #(
   parameter int unsigned TONE_LEN = tocm_pkg::TONE_CYC // tone length in cycles
) (
   input wire logic     pclk,    // clock
   input wire logic     presetn, // async reset, active low
   tocm_tone_if.gen     tn       // start in, drive out
);
   logic [tocm_pkg::TIMER_W-1:0] len_q;  // remaining tone cycles
   logic [15:0]                  half_q; // half-period counter
   logic                         ph_q;   // square wave phase

   // tone length; a restart during a tone lengthens it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_q <= '0;
      end else if (tn.start) begin
         len_q <= tocm_pkg::TIMER_W'(TONE_LEN);
      end else if (len_q != '0) begin
         len_q <= len_q - 1'b1;
      end
   end

   // square wave near 4 khz from the system clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q <= '0;
         ph_q   <= 1'b0;
      end else if (len_q == '0) begin
         half_q <= '0;
         ph_q   <= 1'b0;
      end else if (half_q == 16'(tocm_pkg::TONE_HALF_CYC - 1)) begin
         half_q <= '0;
         ph_q   <= ~ph_q;
      end else begin
         half_q <= half_q + 1'b1;
      end
   end

   // opposite polarity on the two pins, h-bridge style
   assign tn.active = (len_q != '0);
   assign tn.drv_a  = ph_q;
   assign tn.drv_b  = ~ph_q;
endmodule // tocm_tone
`default_nettype wire

// [rtl/tocm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tocm_top #(
   parameter int unsigned HOLD_SHORT = tocm_pkg::HOLD_SHORT_CYC, // 10 s hold in cycles
   parameter int unsigned HOLD_LONG  = tocm_pkg::HOLD_LONG_CYC,  // 60 s hold in cycles
   parameter int unsigned PULSE_LEN  = tocm_pkg::PULSE_CYC,      // output pulse cycles
   parameter int unsigned TONE_LEN   = tocm_pkg::TONE_CYC        // tone cycles
) (
   input  wire logic        pclk,          // clock, 10 mhz
   input  wire logic        presetn,       // async reset, power-up
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb write
   input  wire logic [7:0]  paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output var  logic [31:0] prdata,        // apb read data
   output var  logic        pready,        // apb ready
   output var  logic        pslverr,       // apb error
   output var  logic        irq,           // level interrupt
   input  wire logic        mode_strap_a,  // strap pin a
   input  wire logic        mode_strap_b,  // strap pin b
   input  wire logic        burst_req,     // acquisition wants a burst
   input  wire logic        burst_done,    // burst finished pulse
   input  wire logic        burst_det,     // burst over threshold
   output var  logic        burst_go,      // burst may start now
   output var  logic        recal,         // full recalibration pulse
   output var  logic        out_o,         // output pin level
   output var  logic        out_oe,        // output pin enable
   output var  logic        sense_pin_a_o, // sense pin a level
   output var  logic        sense_pin_a_oe,// sense pin a enable
   output var  logic        sense_pin_b_o, // sense pin b level
   output var  logic        sense_pin_b_oe // sense pin b enable
);
   localparam int unsigned TW = tocm_pkg::TIMER_W;

   // strap synchronisers and captured configuration
   logic [1:0]           sa_q, sb_q;      // two-stage sync
   logic [1:0]           cfg_wait_q;      // settle delay after reset
   logic                 cfg_ok_q;        // straps captured
   tocm_pkg::tocm_mode_t mode_q;          // decoded mode
   logic                 long_q;          // 60 s hold chosen
   // detection path
   logic [2:0]           integ_q;         // integrator count
   logic                 det_q;           // integrated detection
   logic                 det_prev_q;      // for edge detect
   logic                 det_rise;        // new detection
   logic [TW-1:0]        hold_q;          // hold timer
   logic [TW-1:0]        hold_lim;        // selected limit
   logic                 tmo;             // hold limit reached
   // output state
   logic                 dc_block_q;      // dc output held off
   logic                 tog_q;           // toggle state
   logic [TW-1:0]        pulse_q;         // pulse remaining
   logic                 act;             // mode output state
   logic [15:0]          hb_q;            // health gap remaining
   logic                 hb_pend_q;       // burst waiting on gap
   // registers
   logic [31:0]          ctrl_q;          // control
   logic [tocm_pkg::IRQ_W-1:0] ist_q;     // sticky events
   logic [tocm_pkg::IRQ_W-1:0] imk_q;     // event mask
   logic [tocm_pkg::IRQ_W-1:0] ev;        // events this cycle
   logic                 setup, wr_en;    // apb phases
   logic                 hit;             // mapped address
   logic [31:0]          rd;              // read mux

   tocm_tone_if tn ();

   // strap pins come from outside: two flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sa_q <= 2'h0;
         sb_q <= 2'h0;
      end else begin
         sa_q <= {sa_q[0], mode_strap_a};
         sb_q <= {sb_q[0], mode_strap_b};
      end
   end

   // capture once after reset release, never again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_wait_q <= 2'h0;
         cfg_ok_q   <= 1'b0;
         mode_q     <= tocm_pkg::MODE_DC;
         long_q     <= 1'b0;
      end else if (!cfg_ok_q) begin
         if (cfg_wait_q != 2'h3) begin
            cfg_wait_q <= cfg_wait_q + 1'b1; // let sync fill
         end else begin
            cfg_ok_q <= 1'b1;
            // decode of the strap pair
            unique case ({sa_q[1], sb_q[1]})
               2'b11: begin
                  mode_q <= tocm_pkg::MODE_DC;
                  long_q <= 1'b0;
               end
               2'b10: begin
                  mode_q <= tocm_pkg::MODE_DC;
                  long_q <= 1'b1;
               end
               2'b00: begin
                  mode_q <= tocm_pkg::MODE_TOGGLE;
                  long_q <= 1'b0;
               end
               2'b01: begin
                  mode_q <= tocm_pkg::MODE_PULSE;
                  long_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // hold limit: only dc mode may pick the long one
   assign hold_lim = long_q ? TW'(HOLD_LONG) : TW'(HOLD_SHORT);
   assign tmo      = det_q && (hold_q >= hold_lim - 1'b1);

   // recalibration: power-up capture or hold timeout, no pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recal <= 1'b0;
      end else begin
         recal <= (!cfg_ok_q && cfg_wait_q == 2'h3)
                  || tmo;
      end
   end

   // integrator: four detecting bursts in a row
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integ_q <= 3'h0;
      end else if (!cfg_ok_q || tmo) begin
         integ_q <= 3'h0; // restart after recalibration
      end else if (burst_done) begin
         if (!burst_det) begin
            integ_q <= 3'h0;
         end else if (integ_q != 3'(tocm_pkg::INTEG_LIMIT)) begin
            integ_q <= integ_q + 1'b1;
         end
      end
   end

   // integrated detection and its rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det_q      <= 1'b0;
         det_prev_q <= 1'b0;
      end else begin
         det_q      <= (integ_q == 3'(tocm_pkg::INTEG_LIMIT)) && !tmo;
         det_prev_q <= det_q;
      end
   end
   assign det_rise = det_q && !det_prev_q;

   // hold timer runs only while detection is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= '0;
      end else if (!det_q || tmo) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_q + 1'b1;
      end
   end

   // dc block: after a timeout stay off until next detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dc_block_q <= 1'b0;
      end else if (tmo && mode_q == tocm_pkg::MODE_DC) begin
         dc_block_q <= 1'b1;
      end else if (det_rise) begin
         dc_block_q <= 1'b0;
      end
   end

   // toggle flop; timeout leaves it alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_q <= 1'b0;
      end else if (det_rise && mode_q == tocm_pkg::MODE_TOGGLE) begin
         tog_q <= ~tog_q;
      end
   end

   // pulse timer; a new detection restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= '0;
      end else if (det_rise && mode_q == tocm_pkg::MODE_PULSE) begin
         pulse_q <= TW'(PULSE_LEN);
      end else if (pulse_q != '0) begin
         pulse_q <= pulse_q - 1'b1;
      end
   end

   // mode output state
   always_comb begin
      unique case (mode_q)
         tocm_pkg::MODE_DC:     act = det_q && !dc_block_q;
         tocm_pkg::MODE_TOGGLE: act = tog_q;
         tocm_pkg::MODE_PULSE:  act = (pulse_q != '0);
         default:               act = 1'b0;
      endcase
   end

   // health gap: tri-state before each burst, then release it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hb_q      <= 16'h0000;
         hb_pend_q <= 1'b0;
         burst_go  <= 1'b0;
      end else begin
         burst_go <= 1'b0;
         if (burst_req && !hb_pend_q) begin
            hb_q      <= 16'(tocm_pkg::HB_CYC);
            hb_pend_q <= 1'b1;
         end else if (hb_pend_q && hb_q == 16'h0001) begin
            hb_q      <= 16'h0000;
            hb_pend_q <= 1'b0;
            burst_go  <= 1'b1; // burst only after the gap
         end else if (hb_q != 16'h0000) begin
            hb_q <= hb_q - 1'b1;
         end
      end
   end

   // output pin: released in the gap, else driven to state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_o  <= 1'b0;
         out_oe <= 1'b0;
      end else begin
         out_oe <= cfg_ok_q && !hb_pend_q;
         out_o  <= act;
      end
   end

   // tone start: new detection, not in pulse mode, if enabled
   assign tn.start = det_rise && mode_q != tocm_pkg::MODE_PULSE
                     && ctrl_q[tocm_pkg::CTRL_TONE_EN];

   tocm_tone #(
      .TONE_LEN (TONE_LEN)
   ) u_tone (
      .pclk    (pclk),
      .presetn (presetn),
      .tn      (tn.gen)
   );

   // sense pins only driven while the tone sounds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_pin_a_o  <= 1'b0;
         sense_pin_b_o  <= 1'b0;
         sense_pin_a_oe <= 1'b0;
         sense_pin_b_oe <= 1'b0;
      end else begin
         sense_pin_a_o  <= tn.drv_a;
         sense_pin_b_o  <= tn.drv_b;
         sense_pin_a_oe <= tn.active;
         sense_pin_b_oe <= tn.active;
      end
   end

   // apb phases; write commits in the access cycle
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready;
   assign hit   = paddr == tocm_pkg::OFS_CTRL || paddr == tocm_pkg::OFS_STAT
                  || paddr == tocm_pkg::OFS_IRQST || paddr == tocm_pkg::OFS_IRQMK;

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= tocm_pkg::CTRL_RST;
      end else if (wr_en && paddr == tocm_pkg::OFS_CTRL) begin
         ctrl_q <= {31'h0000_0000, pwdata[tocm_pkg::CTRL_TONE_EN]};
      end
   end

   // events: new detection and timeout recalibration
   assign ev[tocm_pkg::IRQ_DET] = det_rise;
   assign ev[tocm_pkg::IRQ_TMO] = tmo;

   // sticky status, write one clears, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= '0;
      end else if (wr_en && paddr == tocm_pkg::OFS_IRQST) begin
         ist_q <= (ist_q & ~pwdata[tocm_pkg::IRQ_W-1:0]) | ev;
      end else begin
         ist_q <= ist_q | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imk_q <= tocm_pkg::IRQ_MK_RST;
      end else if (wr_en && paddr == tocm_pkg::OFS_IRQMK) begin
         imk_q <= pwdata[tocm_pkg::IRQ_W-1:0];
      end
   end

   // level interrupt from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ist_q & imk_q);
      end
   end

   // read mux; unmapped reads give zero
   always_comb begin
      rd = 32'h0000_0000;
      unique case (paddr)
         tocm_pkg::OFS_CTRL: rd = ctrl_q;
         tocm_pkg::OFS_STAT: begin
            rd[tocm_pkg::STAT_MODE_LSB +: 2] = mode_q;
            rd[tocm_pkg::STAT_LONG]          = long_q;
            rd[tocm_pkg::STAT_DET]           = det_q;
            rd[tocm_pkg::STAT_OUT]           = act;
            rd[tocm_pkg::STAT_TONE]          = tn.active;
            rd[tocm_pkg::STAT_CFG_OK]        = cfg_ok_q;
            rd[tocm_pkg::STAT_INT_LSB +: 3]  = integ_q;
         end
         tocm_pkg::OFS_IRQST: rd[tocm_pkg::IRQ_W-1:0] = ist_q;
         tocm_pkg::OFS_IRQMK: rd[tocm_pkg::IRQ_W-1:0] = imk_q;
         default: rd = 32'h0000_0000;
      endcase
   end

   // answer one cycle after setup: data, ready, error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !hit;
         if (setup && !pwrite) begin
            prdata <= rd; // sampled in setup, stable in access
         end
      end
   end
endmodule // tocm_top
`default_nettype wire

// [verification/tocm_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tocm_top_sva (
   input wire logic pclk,           // clock
   input wire logic presetn,        // power-up reset
   input wire logic psel,           // apb select
   input wire logic penable,        // apb enable
   input wire logic pready,         // apb ready
   input wire logic pslverr,        // apb error
   input wire logic burst_go,       // gap over
   input wire logic recal,          // recalibration pulse
   input wire logic out_oe,         // output enable
   input wire logic sense_pin_a_o,  // pin a level
   input wire logic sense_pin_a_oe, // pin a enable
   input wire logic sense_pin_b_o,  // pin b level
   input wire logic sense_pin_b_oe  // pin b enable
);
   localparam logic [11:0] GAP_MAX = 12'hE10; // 3600, gap plus margin
   logic [11:0] gap_q; // cycles with output released

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // saturating gap counter, a stuck tri-state would run past the bound
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 12'h000;
      end else if (out_oe) begin
         gap_q <= 12'h000;
      end else if (gap_q != 12'hFFF) begin
         gap_q <= gap_q + 12'h001;
      end
   end

   property p_recal_pulse; recal |=> !recal; endproperty
   a_recal_pulse: assert property (p_recal_pulse) else $error("recal wider than a cycle");
   property p_setup_ready; psel && !penable |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_go_oe; burst_go |=> out_oe; endproperty
   a_go_oe: assert property (p_go_oe) else $error("output not driven after gap");
   property p_gap_len; gap_q <= GAP_MAX; endproperty
   a_gap_len: assert property (p_gap_len) else $error("output released too long");
   property p_gap_hold; $fell(out_oe) |-> !out_oe [*8]; endproperty
   a_gap_hold: assert property (p_gap_hold) else $error("health gap too short");
   property p_tone_diff;
      sense_pin_a_oe || sense_pin_b_oe |-> sense_pin_a_oe && sense_pin_b_oe && (sense_pin_a_o != sense_pin_b_o);
   endproperty
   a_tone_diff: assert property (p_tone_diff) else $error("tone pins not opposite");
   property p_tone_sq; $rose(sense_pin_a_oe) |-> ##2 ($stable(sense_pin_a_o) && sense_pin_a_oe) [*8]; endproperty
   a_tone_sq: assert property (p_tone_sq) else $error("tone toggles too fast");
endmodule // tocm_top_sva

bind tocm_top tocm_top_sva i_tocm_top_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .burst_go(burst_go), .recal(recal), .out_oe(out_oe),
   .sense_pin_a_o(sense_pin_a_o), .sense_pin_a_oe(sense_pin_a_oe),
   .sense_pin_b_o(sense_pin_b_o), .sense_pin_b_oe(sense_pin_b_oe)
);
`default_nettype wire

// [verification/tocm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tocm_host_model (
   input  wire logic [1:0] cfg,          // wanted straps, {a,b}
   input  wire logic       out_o,        // device output level
   input  wire logic       out_oe,       // device output enable
   output var  logic       mode_strap_a, // strap a wiring
   output var  logic       mode_strap_b, // strap b wiring
   output var  logic       out_line      // line seen by the host
);
   // straps are tied hard, the device has no pulls of its own
   always_comb begin
      mode_strap_a = cfg[1];
      mode_strap_b = cfg[0];
   end
   // pull-up load, so a released line reads high
   assign out_line = out_oe ? out_o : 1'b1;
endmodule // tocm_host_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned HS = 200;  // short hold, scaled
   localparam int unsigned HL = 600;  // long hold, scaled
   localparam int unsigned PL = 50;   // pulse length, scaled
   logic        pclk = 1'b0;          // 10 mhz clock
   logic        presetn, psel, penable, pwrite, burst_req, burst_done, burst_det;
   logic [7:0]  paddr;                // apb address
   logic [31:0] pwdata, prdata, rd;   // apb data, last read
   logic        pready, pslverr, irq, err_s, burst_go, recal, out_o, out_oe, out_line;
   logic        mode_strap_a, mode_strap_b;
   logic        sense_pin_a_o, sense_pin_a_oe, sense_pin_b_o, sense_pin_b_oe;
   logic [1:0]  cfg_q;                // strap wiring {a,b}
   logic [31:0] seed = 32'd95925;     // xorshift state
   int          num_errors = 0, check_count = 0, recal_n = 0;

   always #50 pclk = ~pclk;

   tocm_top #(.HOLD_SHORT(HS), .HOLD_LONG(HL), .PULSE_LEN(PL), .TONE_LEN(3000)) i_tocm_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
      .burst_req(burst_req), .burst_done(burst_done), .burst_det(burst_det),
      .burst_go(burst_go), .recal(recal), .out_o(out_o), .out_oe(out_oe),
      .sense_pin_a_o(sense_pin_a_o), .sense_pin_a_oe(sense_pin_a_oe),
      .sense_pin_b_o(sense_pin_b_o), .sense_pin_b_oe(sense_pin_b_oe));

   tocm_host_model i_tocm_host_model (.cfg(cfg_q), .out_o(out_o), .out_oe(out_oe),
      .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b), .out_line(out_line));

   // recal pulses seen
   always @(posedge pclk) begin
      if (recal === 1'b1) recal_n++;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // status right after power-up: only the captured config shows
   function automatic logic [31:0] exp_stat(input logic [1:0] c);
      logic [31:0] v;
      v = 32'h0;
      v[1:0] = (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h2 : 2'h0;
      v[tocm_pkg::STAT_LONG] = (c == 2'h2);
      v[tocm_pkg::STAT_CFG_OK] = 1'b1;
      return v;
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            err_s = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            return;
         end
      end
      num_errors++;
      give_verdict();
   endtask

   // one burst result after a random pause
   task automatic burst(input logic d);
      repeat (xs() % 32'h3 + 32'h1) @(posedge pclk);
      burst_done <= 1'b1; burst_det <= d;
      @(posedge pclk);
      burst_done <= 1'b0; burst_det <= ~d;
   endtask

   // supply cycle: straps are set while the part is unpowered
   task automatic power(input logic [1:0] c);
      @(posedge pclk);
      presetn <= 1'b0; cfg_q <= c;
      repeat (4) @(posedge pclk);
      recal_n = 0;
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(32'(recal_n), 32'h1);
   endtask

   // one request, count released cycles until burst_go
   task automatic health();
      int n, k;
      @(posedge pclk) burst_req <= 1'b1;
      @(posedge pclk) burst_req <= 1'b0;
      n = 0;
      k = 0;
      // bounded by clock cycles, not by released cycles, so a stuck pin cannot hang
      while (burst_go !== 1'b1 && k < 5000) begin
         @(posedge pclk);
         k++;
         if (out_oe === 1'b0) n++;
         if (n == 1000) chk({31'h0, out_line}, 32'h1);
      end
      if (burst_go !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
      chk(32'(n), 32'(tocm_pkg::HB_CYC));
   endtask

   initial begin
      logic [1:0] c;
      logic [1:0] tbl [4];
      int hold, r0;
      tbl = '{2'h3, 2'h2, 2'h0, 2'h1};
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; burst_req = 1'b0; burst_done = 1'b0; burst_det = 1'b0; cfg_q = 2'h3;
      for (int i = 0; i < 4; i++) begin
         c = tbl[i];
         hold = (c == 2'h2) ? HL : HS;
         power(c);
         cfg_q <= 2'(xs()); // straps move without a supply cycle
         apb(1'b0, tocm_pkg::OFS_STAT, 32'h0);
         chk(rd, exp_stat(c));
         apb(1'b1, tocm_pkg::OFS_IRQMK, 32'h3);
         if (c == 2'h2) apb(1'b1, tocm_pkg::OFS_CTRL, 32'h0);
         repeat (3) burst(1'b1);
         burst(1'b0);
         repeat (3) burst(1'b1);
         repeat (3) @(posedge pclk);
         chk({31'h0, out_line}, 32'h0);
         chk({31'h0, irq}, 32'h0);
         burst(1'b1);
         repeat (4) @(posedge pclk);
         chk({31'h0, out_line}, 32'h1);
         chk({31'h0, irq}, 32'h1);
         chk({31'h0, sense_pin_a_oe}, 32'(c[1] == c[0]));
         r0 = recal_n;
         if (c == 2'h1) begin
            repeat (PL) @(posedge pclk);
            chk({31'h0, out_line}, 32'h0);
            burst(1'b1);
            repeat (3) @(posedge pclk);
            chk({31'h0, out_line}, 32'h0);
         end
         repeat (hold + 10) @(posedge pclk);
         chk(32'(recal_n - r0), 32'h1);
         chk({31'h0, out_line}, 32'(c == 2'h0));
         if (c == 2'h0) begin
            repeat (4) burst(1'b1);
            repeat (4) @(posedge pclk);
            chk({31'h0, out_line}, 32'h0);
         end
         if (c == 2'h2) begin
            health();
            repeat (2) @(posedge pclk);
            chk({31'h0, out_line}, 32'h0);
         end
         apb(1'b1, tocm_pkg::OFS_IRQMK, 32'h0);
         repeat (3) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, tocm_pkg::OFS_IRQST, 32'h3);
         apb(1'b1, tocm_pkg::OFS_IRQMK, 32'h3);
         repeat (3) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         $display("test with straps %h done", c);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err_s}, 32'h1);
      chk(rd, 32'h0);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
